//--- eps_emulation_port_select.sv
// Emulation port takeover, boot mode latch, bus grant and I/O move logic.
`timescale 1ns/1ps
`include "eps_defs.svh"
module eps_emulation_port_select (
  // Clock and reset.
  input  wire logic                       REF_CLK,
  input  wire logic                       RST,
  // Normal control pins.
  input  wire logic                       RESET_N,
  input  wire logic                       BUS_REQ_N,
  output logic                            BUS_GRANT_N_O,
  output logic                            BUS_GRANT_N_OE,
  // Emulator pins.
  input  wire logic                       EMU_TAKEOVER_ENABLE,
  input  wire logic                       EMU_RESET_N,
  input  wire logic                       EMU_BUS_REQ_N,
  output logic                            EMU_BUS_GRANT_N,
  // Boot mode pins and latched mode.
  input  wire logic [`EPS_MODE_W-1:0]     MODE_PINS,
  output logic [`EPS_MODE_W-1:0]          BOOT_MODE,
  // Core status.
  input  wire logic                       EXT_ACCESS_BUSY,
  output logic                            CHIP_RESET,
  output logic                            CORE_HALT,
  output logic                            MEM_DRIVE_EN,
  // I/O move request and data registers.
  input  wire eps_pkg::eps_io_req_type    IO_REQ,
  input  wire logic [`EPS_WORD_W-1:0]     IO_RD_DATA,
  output eps_pkg::eps_io_bus_type         IO_BUS,
  output logic [`EPS_WORD_W-1:0]          DREG_VIEW [`EPS_DREG_CNT]
);
  // ************************************************************
  // Pin selection
  // ************************************************************
  logic emu_sel;
  logic rst_n_sel;
  logic breq_n_sel;

  // Emulator pins only matter while takeover is active.
  // gate emulator pins
  assign emu_sel = EMU_TAKEOVER_ENABLE;

  eps_pin_mux u_rst_mux (
    .sel_emu (emu_sel),
    .norm_in (RESET_N),
    .emu_in  (EMU_RESET_N),
    .chosen  (rst_n_sel)
  );

  eps_pin_mux u_breq_mux (
    .sel_emu (emu_sel),
    .norm_in (BUS_REQ_N),
    .emu_in  (EMU_BUS_REQ_N),
    .chosen  (breq_n_sel)
  );

  // ************************************************************
  // Reset and boot mode latch
  // ************************************************************
  logic                   rst_n_prev_r;
  logic                   rst_n_prev_nxt;
  logic [`EPS_MODE_W-1:0] mode_r;
  logic [`EPS_MODE_W-1:0] mode_nxt;
  logic                   rst_rise;

  assign rst_rise = rst_n_sel && !rst_n_prev_r;

  // Capture the mode pins when the chosen reset releases.
  always_comb begin
    rst_n_prev_nxt = rst_n_sel;
    mode_nxt       = mode_r;
    if (rst_rise) begin
      mode_nxt = MODE_PINS;
    end
  end

  // Register reset edge tracking and the mode.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rst_n_prev_r <= 1'b0;
      mode_r       <= `EPS_MODE_RST;
    end else begin
      rst_n_prev_r <= rst_n_prev_nxt;
      mode_r       <= mode_nxt;
    end
  end

  assign BOOT_MODE = mode_r;
  // full chip reset while chosen reset low
  assign CHIP_RESET = !rst_n_sel;

  // ************************************************************
  // Bus request and grant
  // ************************************************************
  eps_pkg::eps_bus_type bus_r;
  eps_pkg::eps_bus_type bus_nxt;
  logic                 breq;

  assign breq = !breq_n_sel;

  // Grant after any external access ends; request works even in reset.
  always_comb begin
    bus_nxt = bus_r;
    unique case (bus_r)
      eps_pkg::BUS_OWN: begin
        if (breq) begin
          bus_nxt = EXT_ACCESS_BUSY ? eps_pkg::BUS_WAIT : eps_pkg::BUS_GIVEN;
        end
      end
      eps_pkg::BUS_WAIT: begin
        if (!breq) begin
          bus_nxt = eps_pkg::BUS_OWN;
        end else if (!EXT_ACCESS_BUSY) begin
          bus_nxt = eps_pkg::BUS_GIVEN;
        end
      end
      eps_pkg::BUS_GIVEN: begin
        if (!breq) begin
          bus_nxt = eps_pkg::BUS_OWN;
        end
      end
      default: bus_nxt = eps_pkg::BUS_OWN;
    endcase
  end

  // Register the bus ownership state.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      bus_r <= eps_pkg::BUS_OWN;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  logic granted;
  assign granted      = (bus_r == eps_pkg::BUS_GIVEN);
  assign CORE_HALT    = granted;
  assign MEM_DRIVE_EN = !granted;
  // grant on emulator pin, normal grant three-stated
  // emulator grant driven on the emulator pin only, not on the normal grant pin
  assign EMU_BUS_GRANT_N = emu_sel ? !granted : 1'b1;
  assign BUS_GRANT_N_O   = !granted;
  assign BUS_GRANT_N_OE  = !emu_sel;

  // ************************************************************
  // I/O space moves
  // ************************************************************
  logic [`EPS_WORD_W-1:0] dreg_r [`EPS_DREG_CNT];
  logic [`EPS_WORD_W-1:0] dreg_nxt [`EPS_DREG_CNT];
  eps_pkg::eps_io_bus_type io_r;
  eps_pkg::eps_io_bus_type io_nxt;
  logic                    rd_pend_r;
  logic                    rd_pend_nxt;
  logic [`EPS_DREG_W-1:0]  rd_reg_r;
  logic [`EPS_DREG_W-1:0]  rd_reg_nxt;

  // Issue one I/O cycle per request; reads land in the register next cycle.
  always_comb begin
    dreg_nxt    = dreg_r;
    io_nxt      = '0;
    rd_pend_nxt = 1'b0;
    rd_reg_nxt  = rd_reg_r;
    if (rd_pend_r) begin
      dreg_nxt[rd_reg_r] = IO_RD_DATA;
    end
    // word move to any of 2048 locations
    // a grant taken at this edge wins over a new move
    if (IO_REQ.valid && !granted && (bus_nxt != eps_pkg::BUS_GIVEN) && rst_n_sel) begin
      io_nxt.strobe = 1'b1;
      io_nxt.write  = IO_REQ.write;
      io_nxt.addr   = IO_REQ.addr;
      io_nxt.data   = dreg_r[IO_REQ.dreg];
      rd_pend_nxt   = !IO_REQ.write;
      rd_reg_nxt    = IO_REQ.dreg;
    end
  end

  // Register I/O cycle and data registers.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      io_r      <= '0;
      rd_pend_r <= 1'b0;
      rd_reg_r  <= '0;
      for (int i = 0; i < `EPS_DREG_CNT; i++) begin
        dreg_r[i] <= '0;
      end
    end else begin
      io_r      <= io_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_reg_r  <= rd_reg_nxt;
      dreg_r    <= dreg_nxt;
    end
  end

  assign IO_BUS    = io_r;
  assign DREG_VIEW = dreg_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_req_idle;
    breq && !EXT_ACCESS_BUSY && (bus_r == eps_pkg::BUS_OWN);
  endsequence

  a_grant_next_cycle: assert property (@(posedge REF_CLK) disable iff (RST)
    s_req_idle |=> granted && CORE_HALT && !MEM_DRIVE_EN)
    else $error("Grant not given one cycle after idle request.");

  a_grant_in_reset: assert property (@(posedge REF_CLK) disable iff (RST)
    (breq && CHIP_RESET && !EXT_ACCESS_BUSY) |-> ##[1:2] granted)
    else $error("Bus request not honoured during reset.");

  a_no_grant_busy: assert property (@(posedge REF_CLK) disable iff (RST)
    (bus_r == eps_pkg::BUS_OWN && EXT_ACCESS_BUSY) |=> !granted)
    else $error("Grant given during external access.");

  a_mode_latch_rise: assert property (@(posedge REF_CLK) disable iff (RST)
    (rst_n_sel && !$past(rst_n_sel)) |=> (BOOT_MODE == $past(MODE_PINS)))
    else $error("Mode not latched at reset release.");

  a_mode_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    (rst_n_sel && rst_n_prev_r) |=> $stable(BOOT_MODE))
    else $error("Mode changed without reset edge.");

  a_emu_reset_full: assert property (@(posedge REF_CLK) disable iff (RST)
    (emu_sel && !EMU_RESET_N) |-> CHIP_RESET)
    else $error("Emulator reset did not reset chip.");

  a_bg_tristate: assert property (@(posedge REF_CLK) disable iff (RST)
    emu_sel |-> !BUS_GRANT_N_OE && (EMU_BUS_GRANT_N == !granted))
    else $error("Normal grant driven during takeover.");

  a_emu_pins_quiet: assert property (@(posedge REF_CLK) disable iff (RST)
    (!emu_sel && RESET_N) |-> !CHIP_RESET && EMU_BUS_GRANT_N)
    else $error("Emulator pins acted outside takeover.");

  a_io_write_data: assert property (@(posedge REF_CLK) disable iff (RST)
    (IO_REQ.valid && IO_REQ.write && !granted && (bus_nxt != eps_pkg::BUS_GIVEN) && rst_n_sel) |=>
      IO_BUS.strobe && IO_BUS.write && IO_BUS.data == $past(dreg_r[IO_REQ.dreg]))
    else $error("I/O write cycle wrong.");

  a_strobe_off_grant: assert property (@(posedge REF_CLK) disable iff (RST)
    granted |-> !IO_BUS.strobe)
    else $error("I/O strobe driven while bus granted.");
endmodule : eps_emulation_port_select

//--- eps_defs.svh
// Constants for the emulation port takeover logic.
`ifndef EPS_DEFS_SVH
`define EPS_DEFS_SVH
`define EPS_MODE_W      3
`define EPS_MODE_RST    3'h0
`define EPS_IO_ADDR_W   11
`define EPS_IO_ADDR_MAX 11'h7FF
`define EPS_DREG_CNT    16
`define EPS_DREG_W      4
`define EPS_WORD_W      16
`endif

//--- eps_pkg.sv
// Types shared by the emulation port takeover logic.
package eps_pkg;
  // Bus ownership states, Gray coded along OWN, WAIT, GIVEN; a direct grant from OWN flips both bits.
  typedef enum logic [1:0] {
    BUS_OWN   = 2'b00,
    BUS_WAIT  = 2'b01,
    BUS_GIVEN = 2'b11
  } eps_bus_type;

  // One I/O space move request.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  dreg;
    logic [10:0] addr;
  } eps_io_req_type;

  // One I/O space bus cycle toward the pins.
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic [10:0] addr;
    logic [15:0] data;
  } eps_io_bus_type;
endpackage : eps_pkg

//--- eps_pin_mux.sv
// Selects normal or emulator control pins.
`timescale 1ns/1ps
module eps_pin_mux (
  // Selection.
  input  wire logic sel_emu,
  // Normal and emulator sources.
  input  wire logic norm_in,
  input  wire logic emu_in,
  // Chosen level.
  output logic      chosen
);
  // Pick the emulator pin only while takeover is active.
  assign chosen = sel_emu ? emu_in : norm_in;
endmodule : eps_pin_mux

//--- eps_emu_probe.sv
// Emulator probe model that relays target reset and bus request.
`timescale 1ns/1ps
module eps_emu_probe (
  // Bench controls.
  input  wire logic take,
  input  wire logic quiet,
  input  wire logic own_rst_n,
  input  wire logic own_req_n,
  // Target signals.
  input  wire logic tgt_rst_n,
  input  wire logic tgt_req_n,
  // Emulator pins.
  output logic      emu_en,
  output logic      emu_rst_n,
  output logic      emu_req_n
);
  // Takeover follows the bench command.
  assign emu_en = take;
  // target signals dropped
  // While stepping or halted the target is not relayed.
  assign emu_rst_n = (quiet | tgt_rst_n) & own_rst_n;
  assign emu_req_n = (quiet | tgt_req_n) & own_req_n;
endmodule : eps_emu_probe

//--- eps_emulation_port_select_bench.sv
// Self-checking bench for the emulation port takeover logic.
`timescale 1ns/1ps
`include "eps_defs.svh"
module eps_emulation_port_select_bench;
  logic clk, rst, rst_n, req_n, take, quiet, own_rst_n, own_req_n, busy;
  logic emu_en, emu_rst_n, emu_req_n, gnt_n, gnt_oe, emu_gnt_n, chip_rst, halt, drv_en;
  logic [`EPS_MODE_W-1:0]  mode, boot;
  logic [`EPS_WORD_W-1:0]  rd_data;
  logic [`EPS_WORD_W-1:0]  dregs [`EPS_DREG_CNT];
  eps_pkg::eps_io_req_type io_req;
  eps_pkg::eps_io_bus_type io_bus;
  int                      error_cnt = 0;
  int                      checks_done = 0;

  eps_emu_probe u_probe (.take(take), .quiet(quiet), .own_rst_n(own_rst_n), .own_req_n(own_req_n),
    .tgt_rst_n(rst_n), .tgt_req_n(req_n), .emu_en(emu_en), .emu_rst_n(emu_rst_n), .emu_req_n(emu_req_n));

  eps_emulation_port_select u_dut (.REF_CLK(clk), .RST(rst), .RESET_N(rst_n), .BUS_REQ_N(req_n),
    .BUS_GRANT_N_O(gnt_n), .BUS_GRANT_N_OE(gnt_oe), .EMU_TAKEOVER_ENABLE(emu_en),
    .EMU_RESET_N(emu_rst_n), .EMU_BUS_REQ_N(emu_req_n), .EMU_BUS_GRANT_N(emu_gnt_n),
    .MODE_PINS(mode), .BOOT_MODE(boot), .EXT_ACCESS_BUSY(busy), .CHIP_RESET(chip_rst),
    .CORE_HALT(halt), .MEM_DRIVE_EN(drv_en), .IO_REQ(io_req), .IO_RD_DATA(rd_data),
    .IO_BUS(io_bus), .DREG_VIEW(dregs));

  // ****************************************
  // Helpers
  // ****************************************
  // Clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Steps to later falling edges.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Mode latch on reset release, and grant while in reset.
  task automatic t_mode;
    mode = 3'h5;
    req_n = 1'b0;
    cyc(1);
    chk(boot, 3'h0);
    chk({gnt_n, halt}, 2'h1);
    req_n = 1'b1;
    rst_n = 1'b1;
    cyc(1);
    chk(boot, 3'h5);
    chk(gnt_n, 1'b1);
    mode = 3'h2;
    cyc(3);
    chk(boot, 3'h5);
    $display("mode test done");
  endtask : t_mode

  // Grant waits for a busy external access, then follows the request.
  task automatic t_bus;
    busy = 1'b1;
    req_n = 1'b0;
    cyc(2);
    chk({gnt_n, drv_en}, 2'h3);
    busy = 1'b0;
    cyc(1);
    chk({gnt_n, halt, drv_en, gnt_oe, emu_gnt_n}, 5'h0B);
    req_n = 1'b1;
    cyc(1);
    chk({gnt_n, halt, drv_en}, 3'h5);
    $display("bus test done");
  endtask : t_bus

  // Emulator pins idle outside takeover, in charge within it.
  task automatic t_emu;
    own_req_n = 1'b0;
    own_rst_n = 1'b0;
    cyc(2);
    chk({gnt_n, emu_gnt_n, chip_rst}, 3'h6);
    own_req_n = 1'b1;
    own_rst_n = 1'b1;
    take = 1'b1;
    quiet = 1'b1;
    req_n = 1'b0;
    cyc(2);
    chk({gnt_oe, emu_gnt_n, halt}, 3'h2);
    quiet = 1'b0;
    for (int i = 0; i < 4 && emu_gnt_n !== 1'b0; i++) cyc(1);
    chk({gnt_oe, emu_gnt_n, halt}, 3'h1);
    req_n = 1'b1;
    mode = 3'h3;
    own_rst_n = 1'b0;
    cyc(2);
    chk(chip_rst, 1'b1);
    own_rst_n = 1'b1;
    cyc(1);
    chk(boot, 3'h3);
    take = 1'b0;
    $display("emulator test done");
  endtask : t_emu

  // I/O read into the top register, write from it to the top address.
  task automatic t_io;
    io_req = '{1'b1, 1'b0, 4'hF, 11'h000};
    cyc(1);
    chk({io_bus.strobe, io_bus.write, 3'h0, io_bus.addr}, 16'h8000);
    io_req.valid = 1'b0;
    rd_data = 16'hA5C3;
    cyc(1);
    chk(dregs[15], 16'hA5C3);
    io_req = '{1'b1, 1'b1, 4'hF, `EPS_IO_ADDR_MAX};
    cyc(1);
    chk({io_bus.strobe, io_bus.write, 3'h0, io_bus.addr}, 16'hC7FF);
    chk(io_bus.data, 16'hA5C3);
    req_n = 1'b0;
    cyc(1);
    chk({io_bus.strobe, halt}, 2'h1);
    cyc(1);
    chk(io_bus.strobe, 1'b0);
    io_req.valid = 1'b0;
    req_n = 1'b1;
    $display("io test done");
  endtask : t_io

  // Prints the counts and the verdict, then stops.
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Cuts a hang short well after the tests should end.
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end

  // Main sequence.
  initial begin
    {rst, rst_n, req_n, take, quiet, own_rst_n, own_req_n, busy} = 8'hA6;
    mode = 3'h0;
    rd_data = 16'h0000;
    io_req = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_mode();
    t_bus();
    t_emu();
    t_io();
    cyc(2);
    close_out();
  end
endmodule : eps_emulation_port_select_bench
